// ==== hdl/ptr_defines.svh ====
// register offsets, field positions and timing defaults of the tape reader control
`ifndef PTR_DEFINES_SVH
`define PTR_DEFINES_SVH

`define ADDR_W 8
`define ADDR_CTRL 8'h00
`define ADDR_CMD 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_DATA 8'h0C
`define ADDR_ASM_LO 8'h10
`define ADDR_ASM_HI 8'h14

`define CTRL_CONNECT 0
`define CTRL_STOP 1
`define CTRL_ASSEMBLY 2

`define CMD_CLUTCH_SET 0
`define CMD_CLUTCH_CLR 1
`define CMD_DIR_SET 2
`define CMD_DIR_CLR 3

`define DATA_BITS 6
`define HOLE_BITS 7
`define SEVENTH_HOLE 6
`define END_MARK_CODE 6'h3B
`define ASM_BITS 36
`define ASM_HI_BITS 4

`define REV_DELAY_DEF 16'h0400
`define BRAKE_DELAY_DEF 16'h0200

`endif

// ==== hdl/ptr_pkg.sv ====
// types shared by the tape reader control
package ptr_pkg;

    typedef struct packed {
        logic connected;
        logic stop_unit;
        logic assembly;
    } ctrl_t;

    typedef struct packed {
        logic capstan_clutch;
        logic capstan_brake;
        logic reel_clutch;
        logic reel_brake;
        logic reel_booster;
    } drive_t;

    typedef enum logic {SYNC_IDLE, SYNC_WAIT} sync_state_t;

endpackage

// ==== hdl/paper_tape_reader_control.sv ====
// paper_tape_reader_control: feed-hole sync, reader buffer, motor and clutch sequencing
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "ptr_defines.svh"

module paper_tape_reader_control
    import ptr_pkg::*;
#(
    parameter int DELAY_W = 16,
    parameter logic [DELAY_W-1:0] REV_DELAY = `REV_DELAY_DEF,
    parameter logic [DELAY_W-1:0] BRAKE_DELAY = `BRAKE_DELAY_DEF
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rd_data_o,
    input wire logic [`HOLE_BITS-1:0] holes_i,
    input wire logic feed_hole_i,
    input wire logic io_clock_pulse_i,
    input wire logic strip_select_i,
    output logic raise_flag_o,
    output logic motor_reverse_o,
    output logic bin_travel_o,
    output logic move_o,
    output logic capstan_clutch_o,
    output logic capstan_brake_o,
    output logic reel_clutch_o,
    output logic reel_brake_o,
    output logic reel_booster_o
);

    ctrl_t ctrl;
    logic direction_flop;
    logic direction_prev;
    logic clutch;
    logic feed_prev;
    logic feed_edge;
    logic end_mark_level;
    logic [`HOLE_BITS-1:0] char_hold;
    sync_state_t sync_state;
    logic sync_pulse;
    logic buf_load;
    logic [`DATA_BITS-1:0] reader_buffer;
    logic buf_full;
    logic [`ASM_BITS-1:0] asm_word;
    logic move;
    logic next_move;
    logic move_cond;
    logic [1:0] delay_trig;
    logic [1:0] delay_lvl;
    logic bin_travel;
    drive_t next_drive;
    drive_t drive;
    logic data_read;

    assign feed_edge = feed_hole_i & ~feed_prev;
    assign data_read = rd_i && (addr_i == `ADDR_DATA);

    assign end_mark_level = direction_flop && !holes_i[`SEVENTH_HOLE]
                            && (holes_i[`DATA_BITS-1:0] == `END_MARK_CODE);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            feed_prev <= 1'b0;
            char_hold <= '0;
        end else begin
            feed_prev <= feed_hole_i;
            if (feed_edge) begin
                char_hold <= holes_i;
            end
        end
    end

    // feed hole waits for the next io clock pulse
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_state <= SYNC_IDLE;
        end else begin
            case (sync_state)
                SYNC_IDLE: begin
                    if (feed_edge) begin
                        sync_state <= SYNC_WAIT;
                    end
                end
                SYNC_WAIT: begin
                    if (io_clock_pulse_i) begin
                        sync_state <= SYNC_IDLE;
                    end
                end
                default: begin
                    sync_state <= SYNC_IDLE;
                end
            endcase
        end
    end

    assign sync_pulse = (sync_state == SYNC_WAIT) && io_clock_pulse_i;
    // load needs forward travel and a seventh hole
    assign buf_load = sync_pulse && !direction_flop && char_hold[`SEVENTH_HOLE];

    // only six data bits reach the buffer
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reader_buffer <= '0;
        end else if (buf_load) begin
            reader_buffer <= char_hold[`DATA_BITS-1:0];
        end
    end

    // a load in the same cycle as the draining read keeps the flag set
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            buf_full <= 1'b0;
        end else if (buf_load) begin
            buf_full <= 1'b1;
        end else if (data_read) begin
            buf_full <= 1'b0;
        end
    end

    // flag pulse for sequence 52 when connected
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            raise_flag_o <= 1'b0;
        end else begin
            raise_flag_o <= buf_load && ctrl.connected;
        end
    end

    // assembly mode shifts six bits per transfer
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            asm_word <= '0;
        end else if (data_read && ctrl.assembly) begin
            asm_word <= {asm_word[`ASM_BITS-`DATA_BITS-1:0], reader_buffer};
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= '0;
        end else if (wr_i && (addr_i == `ADDR_CTRL)) begin
            ctrl.connected <= wr_data_i[`CTRL_CONNECT];
            ctrl.stop_unit <= wr_data_i[`CTRL_STOP];
            ctrl.assembly <= wr_data_i[`CTRL_ASSEMBLY];
        end
    end

    // unsynchronised end mark reverses to forward when connected
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            direction_flop <= 1'b0;
        end else if (feed_edge && end_mark_level && ctrl.connected) begin
            direction_flop <= 1'b0;
        end else if (wr_i && (addr_i == `ADDR_CMD) && wr_data_i[`CMD_DIR_SET]) begin
            direction_flop <= 1'b1;
        end else if (wr_i && (addr_i == `ADDR_CMD) && wr_data_i[`CMD_DIR_CLR]) begin
            direction_flop <= 1'b0;
        end
    end

    // unconnected end mark stops the tape
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            clutch <= 1'b0;
        end else if (feed_edge && end_mark_level && !ctrl.connected) begin
            clutch <= 1'b0;
        end else if (wr_i && (addr_i == `ADDR_CMD) && wr_data_i[`CMD_CLUTCH_SET]) begin
            clutch <= 1'b1;
        end else if (wr_i && (addr_i == `ADDR_CMD) && wr_data_i[`CMD_CLUTCH_CLR]) begin
            clutch <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            direction_prev <= 1'b0;
        end else begin
            direction_prev <= direction_flop;
        end
    end

    assign move_cond = ctrl.connected && !ctrl.stop_unit && clutch && !delay_lvl[0];
    assign next_move = move_cond;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            move <= 1'b0;
        end else begin
            move <= next_move;
        end
    end

    // reversal delay on any direction change
    assign delay_trig[0] = direction_flop ^ direction_prev;
    // brake delay on each move fall
    assign delay_trig[1] = move && !next_move;

    // retriggerable delay units, lengths in clock cycles
    generate
        for (genvar i = 0; i < 2; i++) begin : g_delay
            logic [DELAY_W-1:0] count;
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    count <= '0;
                end else if (delay_trig[i]) begin
                    count <= (i == 0) ? REV_DELAY : BRAKE_DELAY;
                end else if (count != '0) begin
                    count <= count - 1'b1;
                end
            end
            assign delay_lvl[i] = (count != '0);
        end
    endgenerate

    assign bin_travel = direction_flop ^ delay_lvl[0];

    // strip select holds the reel braked; otherwise the reel follows move
    always_comb begin
        next_drive = '0;
        if (strip_select_i) begin
            next_drive.capstan_clutch = move;
            next_drive.capstan_brake = !move;
            next_drive.reel_clutch = 1'b0;
            next_drive.reel_brake = 1'b1;
            next_drive.reel_booster = 1'b0;
        end else begin
            next_drive.capstan_clutch = bin_travel && (move || delay_lvl[1]);
            next_drive.capstan_brake = !next_drive.capstan_clutch;
            next_drive.reel_clutch = move;
            next_drive.reel_brake = !move;
            next_drive.reel_booster = delay_lvl[1];
        end
    end

    // brakes held on through reset so a powered-up transport cannot coast
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            drive <= '{capstan_brake: 1'b1, reel_brake: 1'b1, default: 1'b0};
            motor_reverse_o <= 1'b0;
            bin_travel_o <= 1'b0;
            move_o <= 1'b0;
        end else begin
            drive <= next_drive;
            motor_reverse_o <= direction_flop;
            bin_travel_o <= bin_travel;
            move_o <= move;
        end
    end

    assign capstan_clutch_o = drive.capstan_clutch;
    assign capstan_brake_o = drive.capstan_brake;
    assign reel_clutch_o = drive.reel_clutch;
    assign reel_brake_o = drive.reel_brake;
    assign reel_booster_o = drive.reel_booster;

    // reads answer one cycle later; unmapped offsets read zero
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                `ADDR_CTRL: rd_data_o <= {29'h0, ctrl.assembly, ctrl.stop_unit,
                                          ctrl.connected};
                `ADDR_STATUS: rd_data_o <= {24'h0, buf_full, delay_lvl[1], delay_lvl[0],
                                            bin_travel, move, clutch, direction_flop,
                                            sync_state == SYNC_WAIT};
                `ADDR_DATA: rd_data_o <= {26'h0, reader_buffer};
                `ADDR_ASM_LO: rd_data_o <= asm_word[31:0];
                `ADDR_ASM_HI: rd_data_o <= {28'h0, asm_word[`ASM_BITS-1:32]};
                default: rd_data_o <= '0;
            endcase
        end else begin
            rd_data_o <= '0;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_end_feed;
        feed_edge && end_mark_level;
    endsequence

    sequence s_wait_pulse;
        (sync_state == SYNC_WAIT) && io_clock_pulse_i;
    endsequence

    a_bin_no_load: assert property (buf_load |-> !direction_flop)
        else $error("buffer loaded during bin travel");
    a_end_mark_code: assert property (end_mark_level |-> direction_flop
        && holes_i[`DATA_BITS-1:0] == `END_MARK_CODE)
        else $error("end mark without code or bin travel");
    a_end_reverse: assert property ((s_end_feed and ctrl.connected) |=> !direction_flop)
        else $error("end mark did not clear direction");
    a_end_clutch: assert property ((s_end_feed and !ctrl.connected)
        |=> !clutch && $stable(direction_flop))
        else $error("unconnected end mark did not stop tape");
    a_load_synced: assert property (buf_load |-> s_wait_pulse)
        else $error("load not on io clock pulse");
    sequence s_fwd_reel;
        !strip_select_i && !bin_travel;
    endsequence

    a_load_data: assert property (buf_load |=> reader_buffer == $past(char_hold[`DATA_BITS-1:0]))
        else $error("buffer does not hold tape data");
    a_raise_flag: assert property (buf_load && ctrl.connected |=> raise_flag_o)
        else $error("flag not raised after load");
    a_rev_delay: assert property ($changed(direction_flop) |=> delay_lvl[0] ##1 !move)
        else $error("reversal delay did not start");
    a_move_level: assert property (move |-> $past(move_cond))
        else $error("move without its conditions");
    a_brake_delay: assert property ($fell(move) |-> delay_lvl[1] ##1 reel_booster_o
        || strip_select_i || $past(strip_select_i))
        else $error("brake delay missing after move fall");
    a_strip_reel: assert property (strip_select_i |=> !reel_clutch_o && reel_brake_o)
        else $error("strip mode reel not braked");
    a_cap_compl: assert property (capstan_clutch_o != capstan_brake_o)
        else $error("capstan clutch and brake overlap");
    a_bin_steady: assert property (direction_flop && !delay_lvl[0] |=> bin_travel_o)
        else $error("bin travel missing in steady bin run");
    a_bin_reverse: assert property (!direction_flop && delay_lvl[0] |=> bin_travel_o)
        else $error("bin travel dropped during reversal");
    a_reel_clutch: assert property (!strip_select_i |=> reel_clutch_o == $past(move)
        && reel_brake_o != reel_clutch_o)
        else $error("reel clutch does not follow move");
    a_reel_boost: assert property (!strip_select_i && !delay_lvl[1] |=> !reel_booster_o)
        else $error("booster outside brake delay");
    a_strip_capstan: assert property (strip_select_i |=> capstan_clutch_o == $past(move))
        else $error("strip capstan does not follow move");
    a_strip_noboost: assert property (strip_select_i |=> !reel_booster_o)
        else $error("booster applied in strip mode");
    a_fwd_drag: assert property (s_fwd_reel |=> capstan_brake_o)
        else $error("forward reel run without capstan drag");
    a_asm_shift: assert property (data_read && ctrl.assembly
        |=> asm_word[`DATA_BITS-1:0] == $past(reader_buffer))
        else $error("assembly word did not take buffer");
    a_bin_no_flag: assert property (direction_flop |=> !raise_flag_o)
        else $error("flag raised during bin travel");

endmodule

// ==== tb/tape_transport.sv ====
// behavioural tape transport: photocell hole levels and feed-hole sensor
`timescale 1ns/1ps
module tape_transport (
    input wire logic mclk_i,
    input wire logic send_i,
    input wire logic [6:0] char_i,
    input wire logic [3:0] hold_i,
    output logic [6:0] holes_o,
    output logic feed_o
);
    logic [3:0] left;
    initial begin
        holes_o = 7'h55;
        feed_o = 1'b0;
        left = 4'h0;
    end
    // a passed column no longer shows its holes, so present the inverse
    always @(posedge mclk_i) begin
        if (send_i) begin
            holes_o <= char_i;
            feed_o <= 1'b1;
            left <= hold_i;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end else if (feed_o) begin
            feed_o <= 1'b0;
            holes_o <= ~holes_o;
        end
    end
endmodule

// ==== tb/test_paper_tape_reader_control.sv ====
// self-checking bench of the tape reader control
`timescale 1ns/1ps
`include "ptr_defines.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
`define WAITV(s, v, n) for (int k = 0; k < n && (s) !== (v); k++) begin @(posedge mclk_i); #1; end

module test_paper_tape_reader_control;
    import ptr_pkg::*;
    localparam int RD = 6;
    localparam int BD = 5;
    logic mclk_i, rst_i, wr_i, rd_i, io, strip, send, feed;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    logic [6:0] holes, ch;
    logic [3:0] hold;
    logic raise_flag_o, motor_reverse_o, bin_travel_o, move_o;
    logic capstan_clutch_o, capstan_brake_o, reel_clutch_o, reel_brake_o, reel_booster_o;
    int failures, n_checks, flags, cycles, f0;
    logic [35:0] exp_asm;

    paper_tape_reader_control #(.DELAY_W(16), .REV_DELAY(16'(RD)), .BRAKE_DELAY(16'(BD))) uut (
        .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr_i),
        .rd_i(rd_i), .rd_data_o(rdata), .holes_i(holes), .feed_hole_i(feed),
        .io_clock_pulse_i(io), .strip_select_i(strip), .raise_flag_o(raise_flag_o),
        .motor_reverse_o(motor_reverse_o), .bin_travel_o(bin_travel_o), .move_o(move_o),
        .capstan_clutch_o(capstan_clutch_o), .capstan_brake_o(capstan_brake_o),
        .reel_clutch_o(reel_clutch_o), .reel_brake_o(reel_brake_o),
        .reel_booster_o(reel_booster_o));

    tape_transport far_side (.mclk_i(mclk_i), .send_i(send), .char_i(ch), .hold_i(hold),
        .holes_o(holes), .feed_o(feed));

    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        if (raise_flag_o === 1'b1) flags++;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        addr <= a;
        wdata <= v;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk_i);
        addr <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic io_pulse();
        @(posedge mclk_i);
        io <= 1'b1;
        @(posedge mclk_i);
        io <= 1'b0;
        repeat (3) @(posedge mclk_i);
    endtask

    // feed edges stay far apart; io pulse only when asked
    task automatic send_char(input logic [6:0] c, input bit with_io);
        @(posedge mclk_i);
        send <= 1'b1;
        ch <= c;
        @(posedge mclk_i);
        send <= 1'b0;
        repeat (4) @(posedge mclk_i);
        if (with_io) io_pulse();
        repeat (hold + 3) @(posedge mclk_i);
        #1;
    endtask

    task automatic t_reset();
        repeat (2) @(posedge mclk_i);
        #1;
        `CHK("reel_brake", 1'b1, reel_brake_o)
        `CHK("reel_clutch", 1'b0, reel_clutch_o)
        `CHK("capstan_brake", 1'b1, capstan_brake_o)
        `CHK("move", 1'b0, move_o)
        rd(8'hFC, d);
        `CHK("unmapped", 32'h0, d)
        $display("test reset done");
    endtask

    task automatic t_motion();
        wr(`ADDR_CTRL, 32'h1);
        wr(`ADDR_CMD, 32'h1);
        `WAITV(move_o, 1'b1, 10)
        `CHK("move_on", 1'b1, move_o)
        `CHK("fwd_capstan_clutch", 1'b0, capstan_clutch_o)
        `CHK("fwd_capstan_brake", 1'b1, capstan_brake_o)
        `CHK("fwd_reel_clutch", 1'b1, reel_clutch_o)
        `CHK("fwd_reel_brake", 1'b0, reel_brake_o)
        wr(`ADDR_CMD, 32'h4);
        `WAITV(reel_booster_o, 1'b1, 10)
        `CHK("booster_on", 1'b1, reel_booster_o)
        `CHK("move_off", 1'b0, move_o)
        `CHK("bin_during_delay", 1'b0, bin_travel_o)
        `CHK("motor_dir", 1'b1, motor_reverse_o)
        `WAITV(move_o, 1'b1, RD + 10)
        `CHK("move_after_delay", 1'b1, move_o)
        `CHK("bin_level", 1'b1, bin_travel_o)
        `CHK("bin_capstan_clutch", 1'b1, capstan_clutch_o)
        `CHK("bin_capstan_brake", 1'b0, capstan_brake_o)
        `WAITV(reel_booster_o, 1'b0, BD + 6)
        `CHK("booster_off", 1'b0, reel_booster_o)
        @(posedge mclk_i);
        strip <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
        `CHK("strip_reel_clutch", 1'b0, reel_clutch_o)
        `CHK("strip_reel_brake", 1'b1, reel_brake_o)
        `CHK("strip_capstan", 1'b1, capstan_clutch_o)
        @(posedge mclk_i);
        strip <= 1'b0;
        $display("test motion done");
    endtask

    task automatic t_endmark();
        hold = 4'h6;
        f0 = flags;
        send_char(7'h4A, 1'b1);
        `CHK("bin_no_load", f0, flags)
        send_char(7'h3B, 1'b0);
        `CHK("end_mark_reverses", 1'b0, motor_reverse_o)
        rd(`ADDR_STATUS, d);
        `CHK("status_dir", 1'b0, d[1])
        hold = 4'h2;
        $display("test end mark done");
    endtask

    task automatic t_load();
        f0 = flags;
        send_char(7'h15, 1'b1);
        `CHK("no_seventh", f0, flags)
        send_char(7'h4A, 1'b0);
        `CHK("unsynced", f0, flags)
        io_pulse();
        `CHK("flag_raised", f0 + 1, flags)
        rd(`ADDR_DATA, d);
        `CHK("data", 32'h0A, d)
        rd(`ADDR_STATUS, d);
        `CHK("full_cleared", 1'b0, d[7])
        $display("test load done");
    endtask

    task automatic t_assembly();
        wr(`ADDR_CTRL, 32'h5);
        exp_asm = '0;
        for (int i = 1; i <= 6; i++) begin
            send_char(7'h40 | 7'(i), 1'b1);
            rd(`ADDR_DATA, d);
            `CHK("asm_data", 32'(i), d)
            exp_asm = {exp_asm[29:0], 6'(i)};
        end
        rd(`ADDR_ASM_LO, d);
        `CHK("asm_lo", exp_asm[31:0], d)
        rd(`ADDR_ASM_HI, d);
        `CHK("asm_hi", 32'(exp_asm[35:32]), d)
        $display("test assembly done");
    endtask

    task automatic t_unconnected();
        wr(`ADDR_CTRL, 32'h0);
        wr(`ADDR_CMD, 32'h4);
        send_char(7'h3B, 1'b0);
        rd(`ADDR_STATUS, d);
        `CHK("clutch_cleared", 1'b0, d[2])
        `CHK("dir_kept", 1'b1, d[1])
        `CHK("end_mark_bin", 1'b1, motor_reverse_o)
        $display("test unconnected done");
    endtask

    initial begin
        {rst_i, wr_i, rd_i, io, strip, send} = 6'h20;
        addr = 8'h00;
        wdata = 32'h0;
        ch = 7'h00;
        hold = 4'h2;
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset();
        t_motion();
        t_endmark();
        t_load();
        t_assembly();
        t_unconnected();
        complete_run();
    end
endmodule
